// file: src/aps_proc_setup.sv
// Purpose: Two setup registers of a multichannel audio processor and their decode
// Assumes: Host reaches the registers over the two-wire control bus pins
// Notes:   Decode outputs lag the registers by one cycle
`timescale 1ns/1ps
module aps_proc_setup #(
  parameter int CHANNELS = 8,
  parameter int WIDTH    = 24,
  parameter int ZERO_RUN = aps_pkg::APS_ZERO_RUN
) (
  input  wire logic                      clk_i,
  input  wire logic                      rstn_i,
  // Control bus pins
  input  wire logic                      scl_i,
  input  wire logic                      sda_i,
  input  wire logic                      addr_sel_i,
  output logic                           sda_o,
  output logic                           sda_oe_n_o,
  // Datapath context
  input  wire logic [1:0]                rate_family_i,
  input  wire logic [1:0]                power_out_mode_i,
  input  wire logic                      sample_valid_i,
  input  wire logic [CHANNELS*WIDTH-1:0] mapped_sample_i,
  input  wire logic [WIDTH-1:0]          ch6_map_i,
  input  wire logic [WIDTH-1:0]          bass_mix_scale_i,
  // Decoded controls
  output logic [9:0]                     ext_clk_ratio_o,
  output logic [11:0]                    proc_clk_ratio_o,
  output logic [26:0]                    proc_clk_hz_o,
  output logic [2:0]                     interp_factor_o,
  output logic [WIDTH-1:0]               ch6_feed_o,
  output logic                           bass_redirect_en_o,
  output logic                           headphone_en_o,
  output logic                           peak_power_fix_o,
  output logic                           filter_bypass_o,
  output logic [2:0]                     in_format_sel_o,
  output logic [4:0]                     in_word_len_o,
  output logic                           in_lsb_first_o,
  output logic                           zc_volume_en_o,
  output logic                           limiter_compress_sel_o,
  output logic [CHANNELS-1:0]            zero_mute_o
);
  import aps_pkg::*;

  // ==========================================================================
  // External clock ratio from interpolation code and clock select
  function automatic logic [9:0] ext_ratio(input logic [1:0] ir, input logic [2:0] sel);
    logic x4;
    x4 = (ir == APS_IR_X4);
    if (sel[2]) begin
      ext_ratio = x4 ? APS_RATIO_128 : APS_RATIO_64;
    end else begin
      case (sel[1:0])
        2'h3:    ext_ratio = x4 ? APS_RATIO_256 : APS_RATIO_128;
        2'h2:    ext_ratio = x4 ? APS_RATIO_384 : APS_RATIO_192;
        2'h1:    ext_ratio = x4 ? APS_RATIO_512 : APS_RATIO_256;
        default: ext_ratio = x4 ? APS_RATIO_768 : APS_RATIO_384;
      endcase
    end
  endfunction

  logic [7:0] proc_setup_a;
  logic [7:0] proc_setup_b;
  logic       bus_wr;
  logic [7:0] bus_wr_addr;
  logic [7:0] bus_wr_data;
  logic [7:0] bus_rd_addr;
  logic [7:0] rd_data;

  // ==========================================================================
  // Control bus slave
  aps_bus_slave u_bus (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .addr_sel_i (addr_sel_i),
    .sda_o      (sda_o),
    .sda_oe_n_o (sda_oe_n_o),
    .wr_o       (bus_wr),
    .wr_addr_o  (bus_wr_addr),
    .wr_data_o  (bus_wr_data),
    .rd_addr_o  (bus_rd_addr),
    .rd_data_i  (rd_data)
  );

  // Address decode; unmapped reads give zero
  wire        hit_a   = (bus_wr_addr == APS_SETUP_A_ADDR);
  wire        hit_b   = (bus_wr_addr == APS_SETUP_B_ADDR);
  assign rd_data = (bus_rd_addr == APS_SETUP_A_ADDR) ? proc_setup_a :
                   (bus_rd_addr == APS_SETUP_B_ADDR) ? proc_setup_b : 8'h00;

  // ==========================================================================
  // Register storage
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      proc_setup_a <= APS_SETUP_A_RST;
      proc_setup_b <= APS_SETUP_B_RST;
    end else if (bus_wr) begin
      if (hit_a) proc_setup_a <= bus_wr_data;
      if (hit_b) proc_setup_b <= bus_wr_data;
    end
  end

  // ==========================================================================
  // Field extraction
  wire [1:0] interp_ratio    = proc_setup_a[APS_A_INTERP_HI:APS_A_INTERP_LO];
  wire [2:0] clock_ratio_sel = proc_setup_a[APS_A_CLKSEL_HI:APS_A_CLKSEL_LO];
  wire [2:0] in_format_sel   = proc_setup_b[APS_B_FMT_HI:APS_B_FMT_LO];
  wire       bass_redirect   = proc_setup_a[APS_A_BASS_REDIR];
  wire       om_ok           = (power_out_mode_i == APS_OM_FIXED) ||
                               (power_out_mode_i == APS_OM_FULL);

  // Clock ratios; external clock at this ratio is the host's duty
  wire [9:0] next_ext_ratio = ext_ratio(interp_ratio, clock_ratio_sel);

  // Interpolation factor and processing clock ratio
  logic [2:0]  next_interp;
  logic [11:0] next_proc_ratio;
  always_comb begin
    case (interp_ratio)
      APS_IR_X2: begin
        next_interp = APS_OSR_X2; next_proc_ratio = APS_PROC_RATIO_X2;
      end
      APS_IR_PASS: begin
        next_interp = APS_OSR_X1; next_proc_ratio = APS_PROC_RATIO_PASS;
      end
      default: begin
        next_interp = APS_OSR_X4; next_proc_ratio = APS_PROC_RATIO_X4;
      end
    endcase
  end

  // Processing clock target by rate family
  wire [26:0] next_pclk = (rate_family_i == APS_FAM_32K)  ? APS_PCLK_32K  :
                          (rate_family_i == APS_FAM_44K1) ? APS_PCLK_44K1 :
                                                            APS_PCLK_48K;

  // Input format with reserved codes folded onto standard serial
  logic [2:0] next_fmt;
  logic [4:0] next_len;
  always_comb begin
    next_len = APS_LEN_24;
    case (in_format_sel)
      APS_FMT_LJ:   next_fmt = APS_FMT_LJ;
      APS_FMT_RJ16: begin
        next_fmt = APS_FMT_RJ16; next_len = APS_LEN_16;
      end
      APS_FMT_RJ18: begin
        next_fmt = APS_FMT_RJ18; next_len = APS_LEN_18;
      end
      APS_FMT_RJ20: begin
        next_fmt = APS_FMT_RJ20; next_len = APS_LEN_20;
      end
      APS_FMT_RJ24: next_fmt = APS_FMT_RJ24;
      default:      next_fmt = APS_FMT_STD;
    endcase
  end

  // ==========================================================================
  // Registered decode outputs
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_clk_ratio_o  <= '0;
      proc_clk_ratio_o <= '0;
      proc_clk_hz_o    <= '0;
      interp_factor_o  <= '0;
      in_format_sel_o  <= '0;
      in_word_len_o    <= '0;
    end else begin
      ext_clk_ratio_o  <= next_ext_ratio;
      proc_clk_ratio_o <= next_proc_ratio;
      proc_clk_hz_o    <= next_pclk;
      interp_factor_o  <= next_interp;
      in_format_sel_o  <= next_fmt;
      in_word_len_o    <= next_len;
    end
  end

  // Mode flags and channel 6 source
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ch6_feed_o             <= '0;
      bass_redirect_en_o     <= 1'b0;
      headphone_en_o         <= 1'b0;
      peak_power_fix_o       <= 1'b0;
      filter_bypass_o        <= 1'b0;
      in_lsb_first_o         <= 1'b0;
      zc_volume_en_o         <= 1'b0;
      limiter_compress_sel_o <= 1'b0;
    end else begin
      ch6_feed_o             <= bass_redirect ? bass_mix_scale_i : ch6_map_i;
      bass_redirect_en_o     <= bass_redirect;
      headphone_en_o         <= proc_setup_a[APS_A_HEADPHONE];
      peak_power_fix_o       <= proc_setup_a[APS_A_PEAK_FIX] && om_ok;
      filter_bypass_o        <= proc_setup_b[APS_B_BYPASS];
      in_lsb_first_o         <= proc_setup_b[APS_B_LSB_FIRST];
      zc_volume_en_o         <= proc_setup_b[APS_B_ZC_VOLUME];
      limiter_compress_sel_o <= proc_setup_b[APS_B_LIMIT_COMP];
    end
  end

  // ==========================================================================
  // Zero-detect auto-mute of mapped channels
  aps_zero_det #(
    .CHANNELS (CHANNELS),
    .WIDTH    (WIDTH),
    .RUN      (ZERO_RUN)
  ) u_zero (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .enable_i (proc_setup_b[APS_B_ZERO_MUTE]),
    .valid_i  (sample_valid_i),
    .sample_i (mapped_sample_i),
    .mute_o   (zero_mute_o)
  );

endmodule

// file: src/aps_pkg.sv
// Purpose: Shared constants for the audio processor setup register pair
// Assumes: 8-bit registers behind a two-wire control bus, 50 MHz clock
// Notes:   Constants and the two-wire slave state type
package aps_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] APS_SETUP_A_ADDR = 8'h00;
  localparam logic [7:0] APS_SETUP_B_ADDR = 8'h01;
  localparam logic [7:0] APS_SETUP_A_RST  = 8'h83;
  localparam logic [7:0] APS_SETUP_B_RST  = 8'h42;

  // ==========================================================================
  // Setup A field positions
  localparam int APS_A_PEAK_FIX   = 7;
  localparam int APS_A_HEADPHONE  = 6;
  localparam int APS_A_BASS_REDIR = 5;
  localparam int APS_A_INTERP_HI  = 4;
  localparam int APS_A_INTERP_LO  = 3;
  localparam int APS_A_CLKSEL_HI  = 2;
  localparam int APS_A_CLKSEL_LO  = 0;

  // Setup B field positions
  localparam int APS_B_LIMIT_COMP = 7;
  localparam int APS_B_ZC_VOLUME  = 6;
  localparam int APS_B_LSB_FIRST  = 5;
  localparam int APS_B_FMT_HI     = 4;
  localparam int APS_B_FMT_LO     = 2;
  localparam int APS_B_ZERO_MUTE  = 1;
  localparam int APS_B_BYPASS     = 0;

  // ==========================================================================
  // Interpolation ratio codes and oversampling factors
  localparam logic [1:0] APS_IR_X4   = 2'h0;
  localparam logic [1:0] APS_IR_X2   = 2'h1;
  localparam logic [1:0] APS_IR_PASS = 2'h2;
  localparam logic [2:0] APS_OSR_X4  = 3'h4;
  localparam logic [2:0] APS_OSR_X2  = 3'h2;
  localparam logic [2:0] APS_OSR_X1  = 3'h1;

  // Processing clock ratio per interp code
  localparam logic [11:0] APS_PROC_RATIO_X4   = 12'h800;
  localparam logic [11:0] APS_PROC_RATIO_X2   = 12'h400;
  localparam logic [11:0] APS_PROC_RATIO_PASS = 12'h200;

  // External clock ratios (multiples of fs)
  localparam logic [9:0] APS_RATIO_64  = 10'h040;
  localparam logic [9:0] APS_RATIO_128 = 10'h080;
  localparam logic [9:0] APS_RATIO_192 = 10'h0c0;
  localparam logic [9:0] APS_RATIO_256 = 10'h100;
  localparam logic [9:0] APS_RATIO_384 = 10'h180;
  localparam logic [9:0] APS_RATIO_512 = 10'h200;
  localparam logic [9:0] APS_RATIO_768 = 10'h300;

  // ==========================================================================
  // Sample rate families and processing clock targets in Hz
  localparam logic [1:0]  APS_FAM_32K   = 2'h0;
  localparam logic [1:0]  APS_FAM_44K1  = 2'h1;
  localparam logic [1:0]  APS_FAM_48K   = 2'h2;
  localparam logic [26:0] APS_PCLK_32K  = 27'h3e80000;
  localparam logic [26:0] APS_PCLK_44K1 = 27'h5622000;
  localparam logic [26:0] APS_PCLK_48K  = 27'h5dc0000;

  // ==========================================================================
  // Serial input formats and right-justified word lengths
  localparam logic [2:0] APS_FMT_STD   = 3'h0;
  localparam logic [2:0] APS_FMT_LJ    = 3'h1;
  localparam logic [2:0] APS_FMT_RJ16  = 3'h2;
  localparam logic [2:0] APS_FMT_RJ18  = 3'h3;
  localparam logic [2:0] APS_FMT_RJ20  = 3'h4;
  localparam logic [2:0] APS_FMT_RJ24  = 3'h5;
  localparam logic [4:0] APS_LEN_16    = 5'h10;
  localparam logic [4:0] APS_LEN_18    = 5'h12;
  localparam logic [4:0] APS_LEN_20    = 5'h14;
  localparam logic [4:0] APS_LEN_24    = 5'h18;

  // Output stage modes in which the peak correction may run
  localparam logic [1:0] APS_OM_FIXED = 2'h0;
  localparam logic [1:0] APS_OM_FULL  = 2'h2;

  // ==========================================================================
  // Control bus and zero detection
  localparam logic [5:0] APS_DEV_ADDR_HI = 6'h0c;
  localparam int         APS_ZERO_RUN    = 2048;

  // Two-wire slave states
  typedef enum logic [2:0] {
    APS_ST_IDLE, APS_ST_DEV, APS_ST_REG, APS_ST_WR, APS_ST_ACK, APS_ST_RD, APS_ST_MACK
  } aps_bus_state_t;

endpackage

// file: src/aps_zero_det.sv
// Purpose: Per-channel consecutive zero sample counter with auto-mute
// Assumes: One valid strobe carries one sample for every channel
// Notes:   Counter saturates at the run length, any non-zero sample restarts it
`timescale 1ns/1ps
module aps_zero_det #(
  parameter int CHANNELS = 8,
  parameter int WIDTH    = 24,
  parameter int RUN      = aps_pkg::APS_ZERO_RUN
) (
  input  wire logic                      clk_i,
  input  wire logic                      rstn_i,
  input  wire logic                      enable_i,
  input  wire logic                      valid_i,
  input  wire logic [CHANNELS*WIDTH-1:0] sample_i,
  output logic      [CHANNELS-1:0]       mute_o
);
  import aps_pkg::*;

  localparam int CW = $clog2(RUN + 1);
  localparam logic [CW-1:0] RUN_C = CW'(RUN);

  logic [CW-1:0] run_cnt [CHANNELS];

  // ==========================================================================
  // Independent run counters, one per mapped channel
  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    wire is_zero = (sample_i[c*WIDTH +: WIDTH] == '0);

    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        run_cnt[c] <= '0;
        mute_o[c]  <= 1'b0;
      end else begin
        if (valid_i) begin
          run_cnt[c] <= !is_zero ? '0 : (run_cnt[c] == RUN_C) ? RUN_C : run_cnt[c] + 1'b1;
        end
        mute_o[c] <= enable_i && (run_cnt[c] == RUN_C);
      end
    end
  end

endmodule

// file: src/aps_bus_slave.sv
// Purpose: Two-wire control bus slave with address byte and auto-increment
// Assumes: Bus pins sampled as synchronous inputs, much slower than clk_i
// Notes:   Open-drain data pin; enable low means the line is pulled low
`timescale 1ns/1ps
module aps_bus_slave (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       addr_sel_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  output logic            wr_o,
  output logic [7:0]      wr_addr_o,
  output logic [7:0]      wr_data_o,
  output logic [7:0]      rd_addr_o,
  input  wire logic [7:0] rd_data_i
);
  import aps_pkg::*;

  aps_bus_state_t state;
  aps_bus_state_t after;
  logic           scl_q;
  logic           sda_q;
  logic [7:0]     shift;
  logic [3:0]     bit_cnt;
  logic           nak;

  // Edge and condition detection
  wire scl_rise = scl_i & ~scl_q;
  wire scl_fall = ~scl_i & scl_q;
  wire start_c  = scl_i & scl_q & sda_q & ~sda_i;
  wire stop_c   = scl_i & scl_q & ~sda_q & sda_i;
  wire byte_in  = (bit_cnt == 4'h8);
  wire dev_hit  = (shift[7:1] == {APS_DEV_ADDR_HI, addr_sel_i});

  assign sda_o = 1'b0;

  // ==========================================================================
  // Byte engine
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_q <= 1'b1; sda_q <= 1'b1; state <= APS_ST_IDLE; after <= APS_ST_IDLE;
      shift <= '0; bit_cnt <= '0; nak <= 1'b0; sda_oe_n_o <= 1'b1;
      wr_o <= 1'b0; wr_addr_o <= '0; wr_data_o <= '0; rd_addr_o <= '0;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      wr_o  <= 1'b0;
      if (start_c) begin
        state <= APS_ST_DEV; bit_cnt <= '0; sda_oe_n_o <= 1'b1;
      end else if (stop_c) begin
        state <= APS_ST_IDLE; sda_oe_n_o <= 1'b1;
      end else begin
        case (state)
          APS_ST_DEV, APS_ST_REG, APS_ST_WR: begin
            if (scl_rise && !byte_in) begin
              shift <= {shift[6:0], sda_i}; bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && byte_in) begin
              sda_oe_n_o <= 1'b0;
              state      <= APS_ST_ACK;
              if (state == APS_ST_DEV) begin
                after <= shift[0] ? APS_ST_RD : APS_ST_REG;
                if (!dev_hit) begin
                  sda_oe_n_o <= 1'b1; state <= APS_ST_IDLE;
                end
              end else if (state == APS_ST_REG) begin
                rd_addr_o <= shift; after <= APS_ST_WR;
              end else begin
                wr_o <= 1'b1; wr_addr_o <= rd_addr_o; wr_data_o <= shift;
                rd_addr_o <= rd_addr_o + 8'h01; after <= APS_ST_WR;
              end
            end
          end
          APS_ST_ACK: if (scl_fall) begin
            bit_cnt <= '0; state <= after; sda_oe_n_o <= 1'b1;
            if (after == APS_ST_RD) begin
              shift <= rd_data_i; sda_oe_n_o <= rd_data_i[7];
              rd_addr_o <= rd_addr_o + 8'h01;
            end
          end
          APS_ST_RD: if (scl_fall) begin
            if (bit_cnt == 4'h7) begin
              sda_oe_n_o <= 1'b1; state <= APS_ST_MACK;
            end else begin
              shift <= {shift[6:0], 1'b0}; sda_oe_n_o <= shift[6];
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          APS_ST_MACK: begin
            if (scl_rise) nak <= sda_i;
            if (scl_fall) begin
              if (nak) begin
                state <= APS_ST_IDLE;
              end else begin
                state <= APS_ST_RD; bit_cnt <= '0; shift <= rd_data_i;
                sda_oe_n_o <= rd_data_i[7]; rd_addr_o <= rd_addr_o + 8'h01;
              end
            end
          end
          default: state <= APS_ST_IDLE;
        endcase
      end
    end
  end

endmodule

// file: test/aps_proc_setup_monitor.sv
// Purpose: Port checks of the setup decode
// Assumes: Decode outputs follow their causes one clock late
// Notes:   Zero-run check watches channel 0 only
`timescale 1ns/1ps
module aps_proc_setup_monitor #(
  parameter int CHANNELS = 8,
  parameter int WIDTH    = 24,
  parameter int ZERO_RUN = 2048
) (
  input wire logic                      clk_i,
  input wire logic                      rstn_i,
  input wire logic [1:0]                rate_family_i,
  input wire logic [1:0]                power_out_mode_i,
  input wire logic                      sample_valid_i,
  input wire logic [CHANNELS*WIDTH-1:0] mapped_sample_i,
  input wire logic [WIDTH-1:0]          ch6_map_i,
  input wire logic [WIDTH-1:0]          bass_mix_scale_i,
  input wire logic [9:0]                ext_clk_ratio_o,
  input wire logic [11:0]               proc_clk_ratio_o,
  input wire logic [26:0]               proc_clk_hz_o,
  input wire logic [2:0]                interp_factor_o,
  input wire logic [WIDTH-1:0]          ch6_feed_o,
  input wire logic                      bass_redirect_en_o,
  input wire logic                      peak_power_fix_o,
  input wire logic [2:0]                in_format_sel_o,
  input wire logic [4:0]                in_word_len_o,
  input wire logic [CHANNELS-1:0]       zero_mute_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ==========================================================================
  // Consecutive zero samples of channel 0, saturating
  logic [15:0] run0;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run0 <= '0;
    end else if (sample_valid_i) begin
      run0 <= (mapped_sample_i[WIDTH-1:0] != '0) ? '0 : run0 + {15'h0, ~&run0};
    end
  end
  // ==========================================================================
  // Decode relations
  a_fix_mode: assert property (
    peak_power_fix_o |-> !$past(power_out_mode_i[0])) else $error("peak fix in wrong mode");
  a_feed_pick: assert property (
    $past(rstn_i) |-> ch6_feed_o == (bass_redirect_en_o ? $past(bass_mix_scale_i)
                                                         : $past(ch6_map_i)))
    else $error("channel 6 source wrong");
  a_ratio_pair: assert property (
    $past(rstn_i) |-> proc_clk_ratio_o == {interp_factor_o, 9'h0}) else $error("proc ratio");
  a_clk_x4: assert property (
    $past(rstn_i) && interp_factor_o == 3'h4 |->
    ext_clk_ratio_o inside {10'h080, 10'h100, 10'h180, 10'h200, 10'h300})
    else $error("x4 clock ratio illegal");
  a_clk_x2: assert property (
    $past(rstn_i) && interp_factor_o != 3'h4 |->
    ext_clk_ratio_o inside {10'h040, 10'h080, 10'h0c0, 10'h100, 10'h180})
    else $error("x2 clock ratio illegal");
  a_pclk_family: assert property (
    $past(rstn_i) |-> proc_clk_hz_o == ($past(rate_family_i) == 2'h0 ? 27'h3e80000 :
                      $past(rate_family_i) == 2'h1 ? 27'h5622000 : 27'h5dc0000))
    else $error("processing clock wrong");
  a_fmt_len: assert property (
    $past(rstn_i) |-> in_word_len_o == (in_format_sel_o == 3'h2 ? 5'h10 :
      in_format_sel_o == 3'h3 ? 5'h12 : in_format_sel_o == 3'h4 ? 5'h14 : 5'h18))
    else $error("word length wrong");
  a_fmt_legal: assert property (
    in_format_sel_o < 3'h6) else $error("reserved format shown");
  a_mute_run: assert property (
    $rose(zero_mute_o[0]) |-> run0 >= ZERO_RUN) else $error("mute too early");
  a_mute_clear: assert property (
    sample_valid_i && mapped_sample_i[WIDTH-1:0] != '0 |-> ##2 !zero_mute_o[0])
    else $error("mute not cleared");
endmodule
bind aps_proc_setup aps_proc_setup_monitor #(
  .CHANNELS(CHANNELS), .WIDTH(WIDTH), .ZERO_RUN(ZERO_RUN)) mon (.*);

// file: test/aps_host.sv
// Purpose: Two-wire bus host reaching the setup registers
// Assumes: Data line pulled up, low when either party pulls it
// Notes:   Each phase is four clocks; data moves two clocks into a phase
`timescale 1ns/1ps
module aps_host (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // Idle bus: both lines released
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end
  // One phase; data changes away from the clock edge
  task automatic ph(input logic c, input logic d);
    scl_o <= c;
    repeat (2) @(posedge clk_i);
    sda_low_o <= ~d;
    repeat (2) @(posedge clk_i);
  endtask
  // Start, also used as repeated start
  task automatic start();
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    ph(1'b0, 1'b0);
  endtask
  // Stop: data rises while clock high
  task automatic stop();
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  // Eight bits then the acknowledge slot, line sampled with clock high
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      ph(1'b0, tx[i]);
      ph(1'b1, tx[i]);
      rx[i] = sda_i;
    end
  endtask
endmodule

// file: test/aps_proc_setup_test.sv
// Purpose: Register access and decode tests for the setup register pair
// Assumes: Zero run shortened to 8 samples
// Notes:   Host model carries all bus traffic
`timescale 1ns/1ps
module aps_proc_setup_test;
  logic         clk_i, rstn_i, addr_sel_i, sample_valid_i, scl, host_low, sda_w, sda_o;
  logic         bass_redirect_en_o, headphone_en_o, peak_power_fix_o, filter_bypass_o;
  logic         in_lsb_first_o, zc_volume_en_o, limiter_compress_sel_o, sda_oe_n_o;
  logic [1:0]   rate_family_i, power_out_mode_i;
  logic [2:0]   interp_factor_o, in_format_sel_o;
  logic [4:0]   in_word_len_o;
  logic [6:0]   dev;
  logic [7:0]   zero_mute_o, v;
  logic [8:0]   r;
  logic [9:0]   ext_clk_ratio_o, x;
  logic [11:0]  proc_clk_ratio_o;
  logic [23:0]  ch6_feed_o, ch6_map_i, bass_mix_scale_i;
  logic [26:0]  proc_clk_hz_o;
  logic [191:0] mapped_sample_i;
  int           n_mismatch, num_checks;
  wire [3:0]    b_bits = {limiter_compress_sel_o, zc_volume_en_o, in_lsb_first_o,
                          filter_bypass_o};
  // Wired-and data line
  assign sda_w = ~host_low & (sda_oe_n_o | sda_o);
  aps_host host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(host_low));
  aps_proc_setup #(.ZERO_RUN(8)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda_w), .addr_sel_i(addr_sel_i),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .rate_family_i(rate_family_i),
    .power_out_mode_i(power_out_mode_i), .sample_valid_i(sample_valid_i),
    .mapped_sample_i(mapped_sample_i), .ch6_map_i(ch6_map_i), .bass_mix_scale_i(bass_mix_scale_i),
    .ext_clk_ratio_o(ext_clk_ratio_o), .proc_clk_ratio_o(proc_clk_ratio_o),
    .proc_clk_hz_o(proc_clk_hz_o), .interp_factor_o(interp_factor_o), .ch6_feed_o(ch6_feed_o),
    .bass_redirect_en_o(bass_redirect_en_o), .headphone_en_o(headphone_en_o),
    .peak_power_fix_o(peak_power_fix_o), .filter_bypass_o(filter_bypass_o),
    .in_format_sel_o(in_format_sel_o), .in_word_len_o(in_word_len_o),
    .in_lsb_first_o(in_lsb_first_o), .zc_volume_en_o(zc_volume_en_o),
    .limiter_compress_sel_o(limiter_compress_sel_o), .zero_mute_o(zero_mute_o));
  // ==========================================================================
  // Helpers
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Byte write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.start();
    host.xfer({dev, 2'h1}, r);
    chk("dev ack", r[0], 1'b0);
    host.xfer({a, 1'b1}, r);
    host.xfer({d, 1'b1}, r);
    chk("data ack", r[0], 1'b0);
    host.stop();
    repeat (3) @(posedge clk_i);
  endtask
  // Byte read via repeated start
  task automatic rd(input logic [7:0] a);
    host.start();
    host.xfer({dev, 2'h1}, r);
    host.xfer({a, 1'b1}, r);
    host.start();
    host.xfer({dev, 2'h3}, r);
    host.xfer(9'h1ff, r);
    v = r[8:1];
    host.stop();
  endtask
  // Sample strobes, three idle clocks apart
  task automatic feed(input int n, input logic [191:0] s);
    repeat (n) begin
      sample_valid_i  <= 1'b1;
      mapped_sample_i <= s;
      @(posedge clk_i);
      sample_valid_i <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask
  // ==========================================================================
  // Clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    end_of_test();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    {rstn_i, addr_sel_i, sample_valid_i, rate_family_i, power_out_mode_i} = '0;
    {mapped_sample_i, dev} = {192'h0, 7'h18};
    {ch6_map_i, bass_mix_scale_i} = {24'h123456, 24'h654321};
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(8'h00);
    chk("setup a", v, 8'h83);
    rd(8'h01);
    chk("setup b", v, 8'h42);
    chk("ext ratio", ext_clk_ratio_o, 10'h100);
    chk("peak fix", peak_power_fix_o, 1'b1);
    $display("reset test done");
    for (int ir = 0; ir < 3; ir++) begin
      for (int m = 0; m < 8; m++) begin
        wr(8'h00, {3'h0, ir[1:0], m[2:0]});
        x = m[2] ? 10'h080 : m == 3 ? 10'h100 : m == 2 ? 10'h180 : m == 1 ? 10'h200 : 10'h300;
        chk("ext ratio", ext_clk_ratio_o, ir == 0 ? x : x >> 1);
        chk("interp", interp_factor_o, 3'h4 >> ir);
        chk("proc ratio", proc_clk_ratio_o, 12'h800 >> ir);
      end
    end
    for (int f = 0; f < 4; f++) begin
      rate_family_i <= f[1:0];
      repeat (3) @(posedge clk_i);
      chk("proc hz", proc_clk_hz_o, f == 0 ? 27'h3e80000 : f == 1 ? 27'h5622000 : 27'h5dc0000);
    end
    $display("clock test done");
    wr(8'h00, 8'he3);
    for (int o = 0; o < 4; o++) begin
      power_out_mode_i <= o[1:0];
      repeat (3) @(posedge clk_i);
      chk("peak fix", peak_power_fix_o, o[0] == 1'b0);
    end
    chk("a bits", {headphone_en_o, bass_redirect_en_o, ch6_feed_o}, {2'h3, 24'h654321});
    power_out_mode_i <= 2'h0;
    wr(8'h00, 8'h03);
    chk("a bits", {headphone_en_o, peak_power_fix_o, ch6_feed_o}, {2'h0, 24'h123456});
    $display("setup a test done");
    for (int s = 0; s < 8; s++) begin
      wr(8'h01, {3'h5, s[2:0], 2'h1});
      rd(8'h01);
      chk("setup b", v, {3'h5, s[2:0], 2'h1});
      chk("format", in_format_sel_o, s > 5 ? 3'h0 : s[2:0]);
      chk("len", in_word_len_o, s == 2 ? 5'h10 : s == 3 ? 5'h12 : s == 4 ? 5'h14 : 5'h18);
    end
    chk("b bits", b_bits, 4'hb);
    wr(8'h01, 8'h42);
    chk("b bits", b_bits, 4'h4);
    rd(8'h05);
    chk("unmapped", v, 8'h00);
    host.start();
    host.xfer({7'h19, 2'h1}, r);
    chk("no ack", r[0], 1'b1);
    host.stop();
    addr_sel_i <= 1'b1;
    dev = 7'h19;
    $display("setup b test done");
    feed(7, 192'h1000000);
    chk("mute", zero_mute_o, 8'h00);
    feed(1, 192'h1000000);
    chk("mute", zero_mute_o, 8'hfd);
    feed(1, 192'h1);
    chk("mute", zero_mute_o, 8'hfc);
    wr(8'h01, 8'h40);
    feed(9, 192'h0);
    chk("mute", zero_mute_o, 8'h00);
    $display("zero test done");
    end_of_test();
  end
endmodule
